// >>> rtl/sdo_axis_pick.sv
`timescale 1ns/1ns
`default_nettype none

// Picks the axis with the largest magnitude and says whether the reported
// direction still carries at least half of one g.
module sdo_axis_pick #(
  parameter logic signed [16:0] HALF_G = sdo_pkg::HALF_G
) (
  input wire logic signed [15:0] accel_x_i,
  input wire logic signed [15:0] accel_y_i,
  input wire logic signed [15:0] accel_z_i,
  input wire logic [1:0] cur_axis_i,
  input wire logic cur_pos_i,
  output logic [1:0] cand_axis_o,
  output logic cand_pos_o,
  output logic cur_weak_o
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Widened by one bit so that the most negative code has a magnitude.
  function automatic logic [16:0] mag(input logic signed [15:0] a);
    logic signed [16:0] e;
    e = {a[15], a};
    mag = e[16] ? 17'(-e) : 17'(e);
  endfunction

  logic [16:0] mx;
  logic [16:0] my;
  logic [16:0] mz;
  logic signed [16:0] along;

  assign mx = mag(accel_x_i);
  assign my = mag(accel_y_i);
  assign mz = mag(accel_z_i);

  // ----------------------------------------------------------------------
  // Candidate: largest magnitude; a positive reading means that axis points
  // away from gravity. Ties favour Z, then Y.
  // ----------------------------------------------------------------------
  always_comb
  begin
    if (mz >= mx && mz >= my)
    begin
      cand_axis_o = sdo_pkg::AXIS_Z; // see [R2]
      cand_pos_o = ~accel_z_i[15]; // see [R1]
    end
    else if (my >= mx)
    begin
      cand_axis_o = sdo_pkg::AXIS_Y;
      cand_pos_o = ~accel_y_i[15];
    end
    else
    begin
      cand_axis_o = sdo_pkg::AXIS_X;
      cand_pos_o = ~accel_x_i[15];
    end
  end

  // Signed reading along the reported direction; a reversed device reads
  // negative and so counts as weak.
  always_comb
  begin
    if (cur_axis_i == sdo_pkg::AXIS_X)
      along = {accel_x_i[15], accel_x_i};
    else if (cur_axis_i == sdo_pkg::AXIS_Y)
      along = {accel_y_i[15], accel_y_i};
    else
      along = {accel_z_i[15], accel_z_i};
    if (!cur_pos_i)
      along = 17'(-along);
  end

  assign cur_weak_o = (along < HALF_G); // see [R2] see [R4]

endmodule

`default_nettype wire

// >>> rtl/sdo_orient.sv
// Contract
// [R1] Report one of six directions, against gravity.
// [R2] Below half g, find largest-magnitude candidate axis.
// [R3] Update when candidate persists and count reaches threshold.
// [R4] Above half g, hold current direction.
// [R5] Packets carry and responses echo identifier 0x1A.
// [R6] Direction fixed until count meets 8-bit threshold.
// [R7] Mode bit 0: decrement or clear on change.
// [R8] Change flag bit 7, cleared by status read.
// [R9] Status bit 2 gives direction sign.
// [R10] Status bits 1:0 give axis code.
// [R11] Debounce total readable as 8-bit field.
// [R12] Host reads both status bytes together.
// [R13] Single-byte config writes accepted.
// [R14] Write config: id, 0x20, offset, count, data.
// [R15] Config read returns id, 0x80, counts, data.
// [R16] Read status: id, 0x30, offset, count.
// [R17] Data placed before command-complete flag sets.
// [R18] Most significant byte in lower mailbox.
// [R19] Count advances per sample, saturating at 0xFF.
`timescale 1ns/1ns
`default_nettype none

module sdo_orient #(
  parameter logic signed [16:0] HALF_G = sdo_pkg::HALF_G,
  parameter int MB_DEPTH = sdo_pkg::MB_DEPTH
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic sample_valid_i,
  input wire logic signed [15:0] accel_x_i,
  input wire logic signed [15:0] accel_y_i,
  input wire logic signed [15:0] accel_z_i,
  input wire logic mb_wr_i,
  input wire logic mb_rd_i,
  input wire logic [$clog2(MB_DEPTH)-1:0] mb_addr_i,
  input wire logic [7:0] mb_wdata_i,
  input wire logic cmd_go_i,
  output logic [7:0] mb_rdata_o,
  output logic command_complete_o,
  output logic busy_o,
  output logic [1:0] axis_o,
  output logic axis_pos_o,
  output logic direction_change_flag_o
);

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  localparam int AW = $clog2(MB_DEPTH);

  logic [7:0] mb [MB_DEPTH];
  sdo_pkg::sdo_state_t state;
  logic [7:0] debounce_threshold;
  logic debounce_counter_mode;
  logic [7:0] debounce_total;
  logic [1:0] cand_prev_axis;
  logic cand_prev_pos;
  logic cand_ok;
  logic [7:0] cmd_id;
  logic [7:0] cmd_op;
  logic [7:0] cmd_off;
  logic [7:0] cmd_cnt;

  logic [1:0] cand_axis;
  logic cand_pos;
  logic cur_weak;
  logic same_cand;
  logic dir_update;
  logic [7:0] next_total;
  logic flag_clear;
  logic [7:0] rsp_code;
  logic [7:0] actual;
  logic [7:0] status_byte;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Bytes of the map that start at the offset and lie inside it.
  function automatic logic [7:0] fit_count(input logic [7:0] off,
                                           input logic [7:0] cnt);
    logic [7:0] room;
    room = 8'(sdo_pkg::REG_BYTES - off);
    if (off >= sdo_pkg::REG_BYTES)
      fit_count = 8'h00;
    else if (cnt < room)
      fit_count = cnt;
    else
      fit_count = room;
  endfunction

  // One byte of the configuration or status map at a byte index.
  function automatic logic [7:0] map_byte(input logic is_sts,
                                          input logic [7:0] idx,
                                          input logic [7:0] thr,
                                          input logic mode,
                                          input logic [7:0] sts,
                                          input logic [7:0] total);
    map_byte = 8'h00;
    if (is_sts)
    begin
      if (idx == sdo_pkg::OFF_STATUS)
        map_byte = sts;
      else if (idx == sdo_pkg::OFF_COUNT)
        map_byte = total; // see [R11]
    end
    else
    begin
      if (idx == sdo_pkg::OFF_THRESHOLD)
        map_byte = thr;
      else if (idx == sdo_pkg::OFF_MODE)
        map_byte = {7'h00, mode};
    end
  endfunction

  // ----------------------------------------------------------------------
  // Direction classifier
  // ----------------------------------------------------------------------
  sdo_axis_pick #(
    .HALF_G(HALF_G)
  ) u_pick (
    .accel_x_i(accel_x_i),
    .accel_y_i(accel_y_i),
    .accel_z_i(accel_z_i),
    .cur_axis_i(axis_o),
    .cur_pos_i(axis_pos_o),
    .cand_axis_o(cand_axis),
    .cand_pos_o(cand_pos),
    .cur_weak_o(cur_weak)
  );

  assign same_cand = cand_ok && cand_axis == cand_prev_axis &&
                     cand_pos == cand_prev_pos;

  // ----------------------------------------------------------------------
  // Debounce decision for one sample
  // ----------------------------------------------------------------------
  // A candidate equal to the reported direction never fires an update, so
  // the change flag only marks real changes.
  always_comb
  begin
    dir_update = 1'b0;
    next_total = debounce_total;
    if (sample_valid_i && cur_weak)
    begin
      if (same_cand)
      begin
        if (debounce_total >= debounce_threshold &&
            (cand_axis != axis_o || cand_pos != axis_pos_o))
        begin
          dir_update = 1'b1; // see [R3] see [R6]
          next_total = 8'h00;
        end
        else if (debounce_total != 8'hFF)
          next_total = 8'(debounce_total + 8'h01); // see [R19]
      end
      else if (debounce_counter_mode)
        next_total = 8'h00; // see [R7]
      else if (debounce_total != 8'h00)
        next_total = 8'(debounce_total - 8'h01); // see [R7]
    end
  end

  // Candidate tracking; a strong reported direction drops the candidate.
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      cand_prev_axis <= sdo_pkg::AXIS_Z;
      cand_prev_pos <= 1'b1;
      cand_ok <= 1'b0;
      debounce_total <= sdo_pkg::COUNT_RST;
    end
    else if (ce_i && sample_valid_i)
    begin
      debounce_total <= next_total;
      if (!cur_weak)
        cand_ok <= 1'b0; // see [R4]
      else
      begin
        cand_prev_axis <= cand_axis;
        cand_prev_pos <= cand_pos;
        cand_ok <= 1'b1;
      end
    end
  end

  // Reported direction; reset value reads as 0x06, positive Z.
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      axis_o <= sdo_pkg::STATUS_RST[1:0];
      axis_pos_o <= sdo_pkg::STATUS_RST[sdo_pkg::POS_BIT];
    end
    else if (ce_i && dir_update)
    begin
      axis_o <= cand_axis; // see [R1] see [R10]
      axis_pos_o <= cand_pos; // see [R9]
    end
  end

  // Change flag: a new change in the cycle of a clearing read wins.
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      direction_change_flag_o <= sdo_pkg::STATUS_RST[sdo_pkg::FLAG_BIT];
    else if (ce_i)
      direction_change_flag_o <= dir_update ||
        (direction_change_flag_o && !flag_clear); // see [R8]
  end

  assign status_byte = {direction_change_flag_o, 4'h0, axis_pos_o,
                        axis_o}; // see [R8] see [R9] see [R10]

  // ----------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------
  always_comb
  begin
    if (cmd_id != sdo_pkg::APP_ID)
      rsp_code = sdo_pkg::RSP_BAD_ID; // see [R5]
    else if (cmd_op == sdo_pkg::OP_RD_CFG || cmd_op == sdo_pkg::OP_WR_CFG ||
             cmd_op == sdo_pkg::OP_RD_STS)
      rsp_code = sdo_pkg::RSP_OK; // see [R15]
    else
      rsp_code = sdo_pkg::RSP_BAD_OP;
  end

  assign actual = (rsp_code == sdo_pkg::RSP_OK) ?
                  fit_count(cmd_off, cmd_cnt) : 8'h00;

  // The status byte is read, and its flag cleared, only when the read
  // really covers offset zero.
  assign flag_clear = state == sdo_pkg::ST_EXEC &&
                      rsp_code == sdo_pkg::RSP_OK &&
                      cmd_op == sdo_pkg::OP_RD_STS &&
                      cmd_off == sdo_pkg::OFF_STATUS &&
                      actual != 8'h00; // see [R8] see [R12]

  // ----------------------------------------------------------------------
  // Command engine
  // ----------------------------------------------------------------------
  // Three steps: latch the packet, place the answer, then raise complete.
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state <= sdo_pkg::ST_IDLE;
      cmd_id <= 8'h00;
      cmd_op <= 8'h00;
      cmd_off <= 8'h00;
      cmd_cnt <= 8'h00;
    end
    else if (ce_i)
    begin
      case (state)
        sdo_pkg::ST_IDLE:
        begin
          if (cmd_go_i)
          begin
            cmd_id <= mb[sdo_pkg::MB_ID];
            cmd_op <= mb[sdo_pkg::MB_CMD];
            cmd_off <= mb[sdo_pkg::MB_OFF];
            cmd_cnt <= mb[sdo_pkg::MB_CNT];
            state <= sdo_pkg::ST_EXEC;
          end
        end
        sdo_pkg::ST_EXEC:
          state <= sdo_pkg::ST_DONE;
        sdo_pkg::ST_DONE:
          state <= sdo_pkg::ST_IDLE;
        default:
          state <= sdo_pkg::ST_IDLE;
      endcase
    end
  end

  // Complete drops when a command starts and rises one cycle after the
  // answer is in the mailboxes.
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      command_complete_o <= 1'b0;
      busy_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (state == sdo_pkg::ST_IDLE && cmd_go_i)
      begin
        command_complete_o <= 1'b0;
        busy_o <= 1'b1;
      end
      else if (state == sdo_pkg::ST_DONE)
      begin
        command_complete_o <= 1'b1; // see [R17]
        busy_o <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Mailboxes
  // ----------------------------------------------------------------------
  // Host writes are taken only while idle, so the engine owns the array
  // while it answers and no byte has two writers in one cycle.
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      for (int i = 0; i < MB_DEPTH; i++)
        mb[i] <= 8'h00;
    end
    else if (ce_i)
    begin
      if (state == sdo_pkg::ST_IDLE && mb_wr_i && !cmd_go_i)
        mb[mb_addr_i] <= mb_wdata_i;
      else if (state == sdo_pkg::ST_EXEC)
      begin
        mb[sdo_pkg::MB_ID] <= cmd_id; // see [R5]
        mb[sdo_pkg::MB_CMD] <= rsp_code; // see [R15]
        mb[sdo_pkg::MB_OFF] <= actual;
        mb[sdo_pkg::MB_CNT] <= cmd_cnt;
        if (cmd_op != sdo_pkg::OP_WR_CFG)
        begin
          for (int k = 0; k < 2; k++)
          begin
            if (8'(k) < actual)
              mb[sdo_pkg::MB_DATA + k] <= map_byte(
                cmd_op == sdo_pkg::OP_RD_STS, 8'(cmd_off + 8'(k)),
                debounce_threshold, debounce_counter_mode,
                status_byte, debounce_total); // see [R17] see [R18]
          end
        end
      end
    end
  end

  // Registered read port for the host.
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      mb_rdata_o <= 8'h00;
    else if (ce_i && mb_rd_i)
      mb_rdata_o <= mb[mb_addr_i];
  end

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  // Bytes land in map order from the first data mailbox; any count of
  // one or two is taken, and bytes past the map are dropped.
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      debounce_threshold <= sdo_pkg::THRESHOLD_RST;
      debounce_counter_mode <= sdo_pkg::MODE_RST[sdo_pkg::MODE_BIT];
    end
    else if (ce_i && state == sdo_pkg::ST_EXEC &&
             rsp_code == sdo_pkg::RSP_OK && cmd_op == sdo_pkg::OP_WR_CFG)
    begin
      for (int k = 0; k < 2; k++)
      begin
        if (8'(k) < actual) // see [R13] see [R14]
        begin
          if (8'(cmd_off + 8'(k)) == sdo_pkg::OFF_THRESHOLD)
            debounce_threshold <= mb[sdo_pkg::MB_DATA + k]; // see [R6]
          else
            debounce_counter_mode <=
              mb[sdo_pkg::MB_DATA + k][sdo_pkg::MODE_BIT]; // see [R7]
        end
      end
    end
  end

endmodule

`default_nettype wire

// >>> rtl/sdo_pkg.sv
package sdo_pkg;

  // ----------------------------------------------------------------------
  // Command packet layout and codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] APP_ID = 8'h1A;
  localparam logic [7:0] OP_RD_CFG = 8'h10;
  localparam logic [7:0] OP_WR_CFG = 8'h20;
  localparam logic [7:0] OP_RD_STS = 8'h30;
  localparam logic [7:0] RSP_OK = 8'h80;
  localparam logic [7:0] RSP_BAD_ID = 8'h81;
  localparam logic [7:0] RSP_BAD_OP = 8'h82;
  localparam int MB_ID = 0;
  localparam int MB_CMD = 1;
  localparam int MB_OFF = 2;
  localparam int MB_CNT = 3;
  localparam int MB_DATA = 4;
  localparam int MB_DEPTH = 8;

  // ----------------------------------------------------------------------
  // Register map, reset values and field positions
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFF_THRESHOLD = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h01;
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_COUNT = 8'h01;
  localparam logic [7:0] REG_BYTES = 8'h02;
  localparam logic [7:0] THRESHOLD_RST = 8'h1E;
  localparam logic [7:0] MODE_RST = 8'h01;
  localparam logic [7:0] STATUS_RST = 8'h06;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam int FLAG_BIT = 7;
  localparam int POS_BIT = 2;
  localparam int MODE_BIT = 0;

  // ----------------------------------------------------------------------
  // Axis codes and front-end scale
  // ----------------------------------------------------------------------
  localparam logic [1:0] AXIS_X = 2'h0;
  localparam logic [1:0] AXIS_Y = 2'h1;
  localparam logic [1:0] AXIS_Z = 2'h2;
  localparam logic signed [16:0] HALF_G = 17'sh02000;

  // ----------------------------------------------------------------------
  // Command engine states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_DONE = 3'b100
  } sdo_state_t;

endpackage

// >>> test/sdo_host_model.sv
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------
// Host processor issuing mailbox command packets
// ------------------------------------------------------------
module sdo_host_model (
  input wire logic clk_i,
  input wire logic [7:0] mb_rdata_i,
  input wire logic command_complete_i,
  output logic mb_wr_o,
  output logic mb_rd_o,
  output logic [2:0] mb_addr_o,
  output logic [7:0] mb_wdata_o,
  output logic cmd_go_o
);
  logic [7:0] rsp [0:5];
  logic [7:0] pkt [0:5];

  // Quiet bus at time zero.
  initial
  begin
    mb_wr_o = 1'b0;
    mb_rd_o = 1'b0;
    mb_addr_o = 3'h0;
    mb_wdata_o = 8'h00;
    cmd_go_o = 1'b0;
  end

  // Loads one packet, starts it, waits for completion, then fetches MB0..MB5.
  task automatic run_cmd(input logic [7:0] id, input logic [7:0] op,
    input logic [7:0] off, input logic [7:0] cnt, input logic [7:0] d0,
    input logic [7:0] d1);
    int n;
    pkt[0] = id;
    pkt[1] = op;
    pkt[2] = off;
    pkt[3] = cnt;
    pkt[4] = d0;
    pkt[5] = d1;
    for (n = 0; n < 6; n++)
    begin
      @(negedge clk_i);
      mb_wr_o = 1'b1;
      mb_addr_o = 3'(n);
      mb_wdata_o = pkt[n];
    end
    @(negedge clk_i);
    mb_wr_o = 1'b0;
    mb_wdata_o = ~mb_wdata_o;
    cmd_go_o = 1'b1;
    @(negedge clk_i);
    cmd_go_o = 1'b0;
    n = 0;
    // Data is only trusted once the complete flag is up.
    while (command_complete_i !== 1'b1 && n < 10)
    begin
      @(negedge clk_i);
      n++;
    end
    // Both status bytes come from one answer, so they agree.
    for (n = 0; n <= 6; n++)
    begin
      @(negedge clk_i);
      if (n > 0)
        rsp[n - 1] = mb_rdata_i;
      mb_rd_o = (n < 6);
      mb_addr_o = 3'(n);
    end
  endtask
endmodule

`default_nettype wire

// >>> test/sdo_orient_bench.sv
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------
// Self-checking bench
// ------------------------------------------------------------
module sdo_orient_bench;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic ce_i = 1'b1;
  logic sample_valid_i = 1'b0;
  logic signed [15:0] ax = 16'sh0000;
  logic signed [15:0] ay = 16'sh0000;
  logic signed [15:0] az = 16'sh0000;
  logic mb_wr, mb_rd, cmd_go, cc, busy, pos, flag;
  logic [2:0] mb_addr;
  logic [7:0] mb_wdata, mb_rdata;
  logic [1:0] axis;
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;

  sdo_orient DUT (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i),
    .sample_valid_i(sample_valid_i), .accel_x_i(ax), .accel_y_i(ay),
    .accel_z_i(az), .mb_wr_i(mb_wr), .mb_rd_i(mb_rd), .mb_addr_i(mb_addr),
    .mb_wdata_i(mb_wdata), .cmd_go_i(cmd_go), .mb_rdata_o(mb_rdata),
    .command_complete_o(cc), .busy_o(busy), .axis_o(axis),
    .axis_pos_o(pos), .direction_change_flag_o(flag));

  sdo_host_model host (.clk_i(clk_i), .mb_rdata_i(mb_rdata),
    .command_complete_i(cc), .mb_wr_o(mb_wr), .mb_rd_o(mb_rd),
    .mb_addr_o(mb_addr), .mb_wdata_o(mb_wdata), .cmd_go_o(cmd_go));

  // Free-running 50 MHz clock.
  always #10 clk_i = ~clk_i;

  // Hang guard, well above the thousand or so cycles the tests need.
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Runs a packet and compares the answer; the count echo is only defined
  // on success, and nd says how many data bytes are defined.
  task automatic cmd(input logic [7:0] id, input logic [7:0] op,
    input logic [7:0] off, input logic [7:0] cnt, input logic [7:0] d0,
    input logic [7:0] d1, input logic [7:0] e1, input logic [7:0] e2,
    input logic [7:0] e4, input logic [7:0] e5, input int nd);
    host.run_cmd(id, op, off, cnt, d0, d1);
    chk(host.rsp[0], id);
    chk(host.rsp[1], e1);
    chk(host.rsp[2], e2);
    if (e1 === 8'h80)
      chk(host.rsp[3], cnt);
    if (nd > 0)
      chk(host.rsp[4], e4);
    if (nd > 1)
      chk(host.rsp[5], e5);
  endtask

  // Status read of both bytes.
  task automatic sts(input logic [7:0] e4, input logic [7:0] e5);
    cmd(8'h1A, 8'h30, 8'h00, 8'h02, 8'h00, 8'h00, 8'h80,
      8'h02, e4, e5, 2);
  endtask

  // Configuration read of two bytes from an offset.
  task automatic rd_cfg(input logic [7:0] off, input logic [7:0] e2,
    input logic [7:0] e4, input logic [7:0] e5, input int nd);
    cmd(8'h1A, 8'h10, off, 8'h02, 8'h00, 8'h00, 8'h80, e2,
      e4, e5, nd);
  endtask

  // Configuration write; the data mailboxes keep what the host wrote.
  task automatic wr_cfg(input logic [7:0] off, input logic [7:0] cnt,
    input logic [7:0] d0, input logic [7:0] d1);
    cmd(8'h1A, 8'h20, off, cnt, d0, d1, 8'h80, cnt, d0, d1, cnt);
  endtask

  // Refused packet: only the echo, the code and a zero count are defined.
  task automatic bad_cmd(input logic [7:0] id, input logic [7:0] op,
    input logic [7:0] e1);
    cmd(id, op, 8'h00, 8'h02, 8'h00, 8'h00, e1, 8'h00, 8'h00,
      8'h00, 0);
  endtask

  // Presents n accelerometer samples, one pulse every other cycle.
  task automatic smp(input logic signed [15:0] x, input logic signed [15:0] y,
    input logic signed [15:0] z, input int n);
    repeat (n)
    begin
      @(negedge clk_i);
      ax = x;
      ay = y;
      az = z;
      sample_valid_i = 1'b1;
      @(negedge clk_i);
      sample_valid_i = 1'b0;
    end
  endtask

  // Test sequence.
  initial
  begin
    repeat (5) @(negedge clk_i);
    reset_i = 1'b0;
    rd_cfg(8'h00, 8'h02, 8'h1E, 8'h01, 2);
    sts(8'h06, 8'h00);
    $display("test 1 finished");
    wr_cfg(8'h00, 8'h02, 8'h03, 8'h01);
    wr_cfg(8'h01, 8'h01, 8'h00, 8'h5A);
    rd_cfg(8'h00, 8'h02, 8'h03, 8'h00, 2);
    rd_cfg(8'h02, 8'h00, 8'h00, 8'h00, 0);
    bad_cmd(8'h2B, 8'h10, 8'h81);
    bad_cmd(8'h1A, 8'h40, 8'h82);
    wr_cfg(8'h01, 8'h01, 8'h01, 8'h00);
    $display("test 2 finished");
    smp(16'sh3000, 16'sh0000, 16'sh0000, 3);
    sts(8'h06, 8'h02);
    smp(16'sh3000, 16'sh0000, 16'sh0000, 1);
    chk({6'h00, axis}, 8'h02);
    smp(16'sh3000, 16'sh0000, 16'sh0000, 1);
    sts(8'h84, 8'h00);
    sts(8'h04, 8'h00);
    $display("test 3 finished");
    smp(16'sh3000, -16'sh7000, 16'sh0000, 5);
    sts(8'h04, 8'h00);
    $display("test 4 finished");
    wr_cfg(8'h01, 8'h01, 8'h00, 8'h00);
    smp(16'sh0000, -16'sh3000, 16'sh0000, 3);
    smp(16'sh0000, -16'sh3000, -16'sh3800, 1);
    sts(8'h04, 8'h01);
    smp(16'sh0000, -16'sh3000, -16'sh3800, 3);
    sts(8'h82, 8'h00);
    $display("test 5 finished");
    wr_cfg(8'h00, 8'h01, 8'hFF, 8'h00);
    smp(16'sh0000, 16'sh0000, -16'sh1000, 260);
    sts(8'h02, 8'hFF);
    $display("test 6 finished");
    // A low clock enable must swallow samples that would move the count.
    ce_i = 1'b0;
    smp(16'sh3000, 16'sh0000, 16'sh0000, 2);
    ce_i = 1'b1;
    sts(8'h02, 8'hFF);
    // A reset in mid-run must bring back every reset value.
    reset_i = 1'b1;
    repeat (2) @(negedge clk_i);
    reset_i = 1'b0;
    rd_cfg(8'h00, 8'h02, 8'h1E, 8'h01, 2);
    sts(8'h06, 8'h00);
    $display("test 7 finished");
    tally_and_finish();
  end
endmodule

`default_nettype wire

// >>> test/sdo_orient_checker.sv
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------
// Port checks on the orientation detector
// ------------------------------------------------------------
module sdo_orient_checker #(
  parameter logic signed [16:0] HALF_G = sdo_pkg::HALF_G
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic sample_valid_i,
  input wire logic signed [15:0] accel_x_i,
  input wire logic signed [15:0] accel_y_i,
  input wire logic signed [15:0] accel_z_i,
  input wire logic mb_rd_i,
  input wire logic cmd_go_i,
  input wire logic [7:0] mb_rdata_o,
  input wire logic command_complete_o,
  input wire logic busy_o,
  input wire logic [1:0] axis_o,
  input wire logic axis_pos_o,
  input wire logic direction_change_flag_o
);
  logic signed [16:0] along;

  // Reading on the reported axis, folded so that it is positive when held.
  always_comb
  begin
    case (axis_o)
      2'h0: along = 17'(accel_x_i);
      2'h1: along = 17'(accel_y_i);
      default: along = 17'(accel_z_i);
    endcase
    if (!axis_pos_o)
      along = -along;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence s_accept;
    ce_i && cmd_go_i && !busy_o;
  endsequence

  sequence s_answer;
    (busy_o && !command_complete_o)[*2] ##1 (command_complete_o && !busy_o);
  endsequence

  a_cmd_answer: assert property (s_accept |=> s_answer)
    else $error("command answer timing wrong");
  a_complete_stands: assert property (command_complete_o
    && !cmd_go_i |=> command_complete_o)
    else $error("complete flag dropped");
  a_rdata_hold: assert property (!(ce_i && mb_rd_i)
    |=> $stable(mb_rdata_o))
    else $error("read data moved without a read");
  a_axis_legal: assert property (axis_o != 2'h3)
    else $error("illegal axis code");
  a_change_flag: assert property ($changed(axis_o)
    || $changed(axis_pos_o)
    |-> direction_change_flag_o && $past(sample_valid_i))
    else $error("direction changed without flag or sample");
  a_idle_hold: assert property (!(ce_i && sample_valid_i)
    |=> $stable(axis_o) && $stable(axis_pos_o))
    else $error("direction moved between samples");
  a_strong_hold: assert property (ce_i && sample_valid_i
    && along >= HALF_G |=> $stable(axis_o) && $stable(axis_pos_o))
    else $error("direction moved while held above half g");
  a_flag_clear: assert property ($fell(direction_change_flag_o)
    |-> busy_o && !command_complete_o)
    else $error("flag cleared outside a status answer");
endmodule

bind sdo_orient sdo_orient_checker #(.HALF_G(HALF_G)) u_chk (
  .clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i),
  .sample_valid_i(sample_valid_i), .accel_x_i(accel_x_i),
  .accel_y_i(accel_y_i), .accel_z_i(accel_z_i), .mb_rd_i(mb_rd_i),
  .cmd_go_i(cmd_go_i), .mb_rdata_o(mb_rdata_o),
  .command_complete_o(command_complete_o), .busy_o(busy_o),
  .axis_o(axis_o), .axis_pos_o(axis_pos_o),
  .direction_change_flag_o(direction_change_flag_o)
);

`default_nettype wire
